// [hdl/dcg_regs.sv]
/*
 * Top of the digitizer clamp and gain register bank: serial control bus
 * slave, register storage, read snapshot and clamp generator instance.
 * Assumes SCL and SDA are synchronous to the clock and much slower than
 * it; SDA is open drain, resolved outside from o_sda_oe_n.
 */
`timescale 1ns/1ns

// How it works
// - Live phase step value is sampled every cycle and readable, no reset.
// - Sync status bit reads 0 with line sync present, 1 missing.
// - Source bit 0 picks internal clamp pulse, 1 external; resets 0.
// - Per-channel clamp on bit, 1 enables, all reset to enabled.
// - Per-channel span bit, 1 middle, 0 bottom; resets to bottom.
// - Twelve-bit clamp begin pixel over two registers, resets to 0x2.
// - Twelve-bit clamp end pixel over two registers, resets to 0x40.
// - External source ignores begin and end values for the pulse.
// - Channels 1 and 2 each have an 8-bit clamp level, resetting to 0x80.
// - Six-bit coarse gain in bits 5..0, resetting to 0x20.
// - Five-bit fine gain in bits 4..0, resetting to 0x10.
// - Channel 2 holds its own level and gains like channel 1.
// - Phase step and sync status reads come from a snapshot taken at start, never torn.
module dcg_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2d  // Arbitrary bus address
) (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_scl,
   input  wire logic                          i_sda,
   output logic                               o_sda,
   output logic                               o_sda_oe_n,
   input  wire logic [dcg_pkg::STEP_W-1:0]    i_phase_step_value,
   input  wire logic                          i_pixel_en,
   input  wire logic                          i_line_sync_input,
   input  wire logic                          i_ext_clamp,
   output logic [dcg_pkg::CHAN_N-1:0]         o_ch_clamp,
   output logic [dcg_pkg::CHAN_N-1:0]         o_clamp_span,
   output logic [dcg_pkg::LEVEL_W-1:0]        o_ch1_clamp_level,
   output logic [dcg_pkg::COARSE_W-1:0]       o_ch1_gain_coarse,
   output logic [dcg_pkg::FINE_W-1:0]         o_ch1_gain_fine,
   output logic [dcg_pkg::LEVEL_W-1:0]        o_ch2_clamp_level,
   output logic [dcg_pkg::COARSE_W-1:0]       o_ch2_gain_coarse,
   output logic [dcg_pkg::FINE_W-1:0]         o_ch2_gain_fine
);
   import dcg_pkg::*;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_ACK_A = 9'h004,
      ST_SUB   = 9'h008,
      ST_ACK_S = 9'h010,
      ST_WR    = 9'h020,
      ST_ACK_W = 9'h040,
      ST_RD    = 9'h080,
      ST_ACK_R = 9'h100
   } dcg_state_t;

   dcg_state_t          state_q;
   logic                scl_q;
   logic                sda_q;
   logic                scl_rise;
   logic                scl_fall;
   logic                bus_start;
   logic                bus_stop;
   logic [7:0]          shift_q;
   logic [7:0]          tx_q;
   logic [3:0]          bit_cnt_q;
   logic [7:0]          sub_q;
   logic                rw_q;
   logic                nack_q;
   logic                drive_q;
   logic                wr_en;
   logic [STEP_W-1:0]   step_live_q;
   logic [STEP_W-1:0]   step_snap_q;
   logic                nosync_snap_q;
   logic [6:0]          ctrl_q;
   logic [PIX_W-1:0]    begin_q;
   logic [PIX_W-1:0]    end_q;
   logic [LEVEL_W-1:0]  lvl1_q;
   logic [COARSE_W-1:0] crs1_q;
   logic [FINE_W-1:0]   fin1_q;
   logic [LEVEL_W-1:0]  lvl2_q;
   logic [COARSE_W-1:0] crs2_q;
   logic [FINE_W-1:0]   fin2_q;

   dcg_clamp_if cif ();

   // ************************************************************
   // Read decode
   // ************************************************************
   // Used when the first and each later read byte is loaded
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         SUB_PHASE_STEP_BYTE0:   r = step_snap_q[7:0];
         SUB_PHASE_STEP_BYTE1:   r = step_snap_q[15:8];
         SUB_PHASE_STEP_BYTE2:   r = step_snap_q[23:16];
         SUB_PHASE_STEP_BYTE3:   r = step_snap_q[31:24];
         SUB_PHASE_STEP_TOP_BIT: r = {7'h00, step_snap_q[32]};
         SUB_SYNC_PRESENCE:      r = {7'h00, nosync_snap_q};
         SUB_CLAMP_CONTROL:      r = {1'b0, ctrl_q};
         SUB_CLAMP_BEGIN_LOW:    r = begin_q[7:0];
         SUB_CLAMP_BEGIN_HIGH:   r = {4'h0, begin_q[11:8]};
         SUB_CLAMP_END_LOW:      r = end_q[7:0];
         SUB_CLAMP_END_HIGH:     r = {4'h0, end_q[11:8]};
         SUB_CH1_CLAMP_LEVEL:    r = lvl1_q;
         SUB_CH1_GAIN_COARSE:    r = {2'h0, crs1_q};
         SUB_CH1_GAIN_FINE:      r = {3'h0, fin1_q};
         SUB_CH2_CLAMP_LEVEL:    r = lvl2_q;
         SUB_CH2_GAIN_COARSE:    r = {2'h0, crs2_q};
         SUB_CH2_GAIN_FINE:      r = {3'h0, fin2_q};
         default:                r = 8'h00;
      endcase
      return r;
   endfunction

   // ************************************************************
   // Bus line sampling and conditions
   // ************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   assign scl_rise  = i_scl && !scl_q;
   assign scl_fall  = !i_scl && scl_q;
   assign bus_start = i_scl && scl_q && sda_q && !i_sda;
   assign bus_stop  = i_scl && scl_q && !sda_q && i_sda;

   // ************************************************************
   // Live value and read snapshot
   // ************************************************************
   // Live copy follows the oscillator; no reset, it is never control
   always_ff @(posedge i_clk_sys) begin
      step_live_q <= i_phase_step_value;
   end

   // Frozen at each start so a multi-byte read is coherent
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         step_snap_q   <= '0;
         nosync_snap_q <= 1'b1;
      end else if (bus_start) begin
         step_snap_q   <= step_live_q;
         nosync_snap_q <= cif.sync_missing;
      end
   end

   // ************************************************************
   // Serial slave state machine
   // ************************************************************
   assign wr_en = (state_q == ST_WR) && scl_fall && (bit_cnt_q == 4'd8);

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_q   <= ST_IDLE;
         shift_q   <= 8'h00;
         tx_q      <= 8'hff;
         bit_cnt_q <= 4'd0;
         sub_q     <= 8'h00;
         rw_q      <= 1'b0;
         nack_q    <= 1'b0;
      end else if (bus_start) begin
         state_q   <= ST_ADDR;
         bit_cnt_q <= 4'd0;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
      end else begin
         if (scl_rise) begin
            shift_q   <= {shift_q[6:0], i_sda};
            bit_cnt_q <= bit_cnt_q + 4'd1;
            if (state_q == ST_ACK_R) begin
               nack_q <= i_sda;
            end
         end
         if (scl_fall) begin
            unique case (state_q)
               ST_IDLE: begin
               end
               ST_ADDR: begin
                  if (bit_cnt_q == 4'd8) begin
                     if (shift_q[7:1] == DEV_ADDR) begin
                        rw_q    <= shift_q[0];
                        state_q <= ST_ACK_A;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A: begin
                  bit_cnt_q <= 4'd0;
                  if (rw_q) begin
                     tx_q    <= rd_byte(sub_q);
                     state_q <= ST_RD;
                  end else begin
                     state_q <= ST_SUB;
                  end
               end
               ST_SUB: begin
                  if (bit_cnt_q == 4'd8) begin
                     sub_q   <= shift_q;
                     state_q <= ST_ACK_S;
                  end
               end
               ST_ACK_S, ST_ACK_W: begin
                  bit_cnt_q <= 4'd0;
                  state_q   <= ST_WR;
               end
               ST_WR: begin
                  if (bit_cnt_q == 4'd8) begin
                     sub_q   <= sub_q + 8'h01;
                     state_q <= ST_ACK_W;
                  end
               end
               ST_RD: begin
                  if (bit_cnt_q == 4'd8) begin
                     state_q <= ST_ACK_R;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b1};
                  end
               end
               ST_ACK_R: begin
                  bit_cnt_q <= 4'd0;
                  if (nack_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     tx_q    <= rd_byte(sub_q + 8'h01);
                     sub_q   <= sub_q + 8'h01;
                     state_q <= ST_RD;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Pull SDA low for acks and zero data bits; changes while SCL is low
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= (state_q == ST_ACK_A) || (state_q == ST_ACK_S) ||
                    (state_q == ST_ACK_W) ||
                    ((state_q == ST_RD) && !tx_q[7]); // Last bit held to ack
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = !drive_q;

   // ************************************************************
   // Writable registers
   // ************************************************************
   // Read-only subaddresses fall through and keep nothing
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         ctrl_q  <= CTRL_RESET;
         begin_q <= BEGIN_RESET;
         end_q   <= END_RESET;
         lvl1_q  <= LEVEL_RESET;
         crs1_q  <= COARSE_RESET;
         fin1_q  <= FINE_RESET;
         lvl2_q  <= LEVEL_RESET;
         crs2_q  <= COARSE_RESET;
         fin2_q  <= FINE_RESET;
      end else if (wr_en) begin
         unique case (sub_q)
            SUB_CLAMP_CONTROL:    ctrl_q <= shift_q[6:0];
            SUB_CLAMP_BEGIN_LOW:  begin_q[7:0] <= shift_q;
            SUB_CLAMP_BEGIN_HIGH: begin_q[11:8] <= shift_q[3:0];
            SUB_CLAMP_END_LOW:    end_q[7:0] <= shift_q;
            SUB_CLAMP_END_HIGH:   end_q[11:8] <= shift_q[3:0];
            SUB_CH1_CLAMP_LEVEL:  lvl1_q <= shift_q;
            SUB_CH1_GAIN_COARSE:  crs1_q <= shift_q[5:0];
            SUB_CH1_GAIN_FINE:    fin1_q <= shift_q[4:0];
            SUB_CH2_CLAMP_LEVEL:  lvl2_q <= shift_q;
            SUB_CH2_GAIN_COARSE:  crs2_q <= shift_q[5:0];
            SUB_CH2_GAIN_FINE:    fin2_q <= shift_q[4:0];
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Control fields out
   // ************************************************************
   assign cif.timing_source = ctrl_q[CTRL_SRC_BIT];
   assign cif.begin_pixel   = begin_q;
   assign cif.end_pixel     = end_q;

   for (genvar c = 0; c < CHAN_N; c++) begin : g_fields
      assign cif.clamp_on[c] = ctrl_q[CTRL_ON_BIT0 - 2 * c];
      assign o_clamp_span[c] = ctrl_q[CTRL_SPAN_BIT0 - 2 * c];
   end

   assign o_ch1_clamp_level = lvl1_q;
   assign o_ch1_gain_coarse = crs1_q;
   assign o_ch1_gain_fine   = fin1_q;
   assign o_ch2_clamp_level = lvl2_q;
   assign o_ch2_gain_coarse = crs2_q;
   assign o_ch2_gain_fine   = fin2_q;

   // ************************************************************
   // Clamp pulse generator
   // ************************************************************
   dcg_clamp_gen u_clamp (
      .i_clk_sys   (i_clk_sys),
      .i_rst_n     (i_rst_n),
      .i_pixel_en  (i_pixel_en),
      .i_line_sync (i_line_sync_input),
      .i_ext_clamp (i_ext_clamp),
      .cif         (cif),
      .o_ch_clamp  (o_ch_clamp)
   );
endmodule

// [hdl/dcg_pkg.sv]
/*
 * Constants of the digitizer clamp and gain register bank: subaddresses,
 * field positions, widths and reset values.
 * Assumes 8-bit registers addressed by an 8-bit subaddress.
 */
package dcg_pkg;

   // ************************************************************
   // Subaddresses
   // ************************************************************
   localparam logic [7:0] SUB_PHASE_STEP_BYTE0   = 8'h14;
   localparam logic [7:0] SUB_PHASE_STEP_BYTE1   = 8'h15;
   localparam logic [7:0] SUB_PHASE_STEP_BYTE2   = 8'h16;
   localparam logic [7:0] SUB_PHASE_STEP_BYTE3   = 8'h17;
   localparam logic [7:0] SUB_PHASE_STEP_TOP_BIT = 8'h18;
   localparam logic [7:0] SUB_SYNC_PRESENCE      = 8'h19;
   localparam logic [7:0] SUB_CLAMP_CONTROL      = 8'h20;
   localparam logic [7:0] SUB_CLAMP_BEGIN_LOW    = 8'h21;
   localparam logic [7:0] SUB_CLAMP_BEGIN_HIGH   = 8'h22;
   localparam logic [7:0] SUB_CLAMP_END_LOW      = 8'h23;
   localparam logic [7:0] SUB_CLAMP_END_HIGH     = 8'h24;
   localparam logic [7:0] SUB_CH1_CLAMP_LEVEL    = 8'h25;
   localparam logic [7:0] SUB_CH1_GAIN_COARSE    = 8'h26;
   localparam logic [7:0] SUB_CH1_GAIN_FINE      = 8'h27;
   localparam logic [7:0] SUB_CH2_CLAMP_LEVEL    = 8'h28;
   localparam logic [7:0] SUB_CH2_GAIN_COARSE    = 8'h29;
   localparam logic [7:0] SUB_CH2_GAIN_FINE      = 8'h2a;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int STEP_W   = 33;
   localparam int PIX_W    = 12;
   localparam int LEVEL_W  = 8;
   localparam int COARSE_W = 6;
   localparam int FINE_W   = 5;
   localparam int CHAN_N   = 3;

   // ************************************************************
   // Clamp control field positions and reset
   // ************************************************************
   localparam int CTRL_SRC_BIT = 6;
   localparam int CTRL_ON_BIT0 = 5;   // Channel n on at 5-2n
   localparam int CTRL_SPAN_BIT0 = 4; // Channel n span at 4-2n
   localparam logic [6:0] CTRL_RESET = 7'h2a;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [PIX_W-1:0]    BEGIN_RESET  = 12'h002;
   localparam logic [PIX_W-1:0]    END_RESET    = 12'h040;
   localparam logic [LEVEL_W-1:0]  LEVEL_RESET  = 8'h80;
   localparam logic [COARSE_W-1:0] COARSE_RESET = 6'h20;
   localparam logic [FINE_W-1:0]   FINE_RESET   = 5'h10;
   localparam logic [PIX_W-1:0]    PIX_MAX      = 12'hfff;

endpackage

// [hdl/dcg_clamp_if.sv]
/*
 * Carrier between the register bank and the clamp pulse generator.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
interface dcg_clamp_if;
   import dcg_pkg::*;

   logic [PIX_W-1:0]  begin_pixel;
   logic [PIX_W-1:0]  end_pixel;
   logic              timing_source;
   logic [CHAN_N-1:0] clamp_on;
   logic              sync_missing;

   modport regs (output begin_pixel, end_pixel, timing_source, clamp_on,
                 input  sync_missing);
   modport gen  (input  begin_pixel, end_pixel, timing_source, clamp_on,
                 output sync_missing);
endinterface

// [hdl/dcg_clamp_gen.sv]
/*
 * Clamp pulse generator: pixel counter restarted by line sync, window
 * compare, source select and per-channel gating; also line-sync presence.
 * Assumes i_pixel_en is a one-cycle pulse per pixel and line sync is
 * active high and synchronous to the clock.
 */
`timescale 1ns/1ns
module dcg_clamp_gen (
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_pixel_en,
   input  wire logic                      i_line_sync,
   input  wire logic                      i_ext_clamp,
   dcg_clamp_if.gen                       cif,
   output logic [dcg_pkg::CHAN_N-1:0]     o_ch_clamp
);
   import dcg_pkg::*;

   logic             sync_q;
   logic [PIX_W-1:0] pix_cnt_q;
   logic             window;
   logic             pulse;

   // ************************************************************
   // Pixel counter
   // ************************************************************
   // Saturates so that a vanished sync is seen as a full count
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sync_q    <= 1'b0;
         pix_cnt_q <= PIX_MAX;
      end else begin
         sync_q <= i_line_sync;
         if (i_line_sync && !sync_q) begin
            pix_cnt_q <= '0;
         end else if (i_pixel_en && pix_cnt_q != PIX_MAX) begin
            pix_cnt_q <= pix_cnt_q + 12'h001;
         end
      end
   end

   // No edge for a whole counter span means line sync is missing
   assign cif.sync_missing = (pix_cnt_q == PIX_MAX);

   // ************************************************************
   // Window and source
   // ************************************************************
   assign window = (pix_cnt_q >= cif.begin_pixel) &&
                   (pix_cnt_q <= cif.end_pixel);
   // External source bypasses the programmed window entirely
   assign pulse  = cif.timing_source ? i_ext_clamp : window;

   // Registered per-channel gating
   for (genvar g = 0; g < CHAN_N; g++) begin : g_chan
      always_ff @(posedge i_clk_sys) begin
         if (!i_rst_n) begin
            o_ch_clamp[g] <= 1'b0;
         end else begin
            o_ch_clamp[g] <= pulse & cif.clamp_on[g];
         end
      end
   end
endmodule

// [dv/dcg_host.sv]
/* Host model: master of the serial control bus, bit-level tasks.
   Assumes the bench resolves SDA from both enables with a pull-up. */
`timescale 1ns/1ns
module dcg_host #(
   parameter logic [6:0] ADDR = 7'h2d
) (
   input  wire logic i_clk_sys,
   input  wire logic i_sda,
   output logic      o_scl = 1'b1,
   output logic      o_sda_oe_n = 1'b1
);
   // ****************************************
   // Bus phases, five clocks so SCL stays over four
   // ****************************************
   task automatic hb();
      repeat (5) @(posedge i_clk_sys);
   endtask
   // SDA moves a clock after SCL falls, so no false start or stop
   task automatic bit_x(input logic b, output logic r);
      @(posedge i_clk_sys);
      o_sda_oe_n <= b;
      hb();
      o_scl <= 1'b1;
      hb();
      r = i_sda;
      o_scl <= 1'b0;
   endtask
   // Start, or repeated start when entered with SCL low
   task automatic start();
      @(posedge i_clk_sys);
      o_sda_oe_n <= 1'b1;
      hb();
      o_scl <= 1'b1;
      hb();
      o_sda_oe_n <= 1'b0;
      hb();
      o_scl <= 1'b0;
   endtask
   task automatic stop();
      @(posedge i_clk_sys);
      o_sda_oe_n <= 1'b0;
      hb();
      o_scl <= 1'b1;
      hb();
      o_sda_oe_n <= 1'b1;
      hb();
   endtask
   task automatic xfer(input logic [7:0] d, input logic b,
                       output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(b, a);
   endtask
   // Byte from the host; a missing acknowledge is remembered
   task automatic send(input logic [7:0] d, inout logic e);
      logic [7:0] q;
      logic a;
      xfer(d, 1'b1, q, a);
      e |= a;
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d,
                     output logic a_n);
      a_n = 1'b0;
      start();
      send({ADDR, 1'b0}, a_n);
      send(sub, a_n);
      send(d, a_n);
      stop();
   endtask
   // Burst read; the host refuses the last byte to end it
   task automatic rd(input logic [7:0] sub, input int n,
                     output logic [7:0] q [16], output logic a_n);
      logic a;
      a_n = 1'b0;
      start();
      send({ADDR, 1'b0}, a_n);
      send(sub, a_n);
      start();
      send({ADDR, 1'b1}, a_n);
      for (int i = 0; i < n; i++) xfer(8'hff, i == n - 1, q[i], a);
      stop();
   endtask
endmodule

// [dv/dcg_regs_sva.sv]
/* Port checker of the clamp and gain register bank.
   Bound to the top module by the bench; sees its ports only. */
`timescale 1ns/1ns
module dcg_regs_sva (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic       i_scl,
   input wire logic       o_sda_oe_n,
   input wire logic [2:0] o_ch_clamp,
   input wire logic [2:0] o_clamp_span,
   input wire logic [7:0] o_ch1_clamp_level,
   input wire logic [5:0] o_ch1_gain_coarse,
   input wire logic [4:0] o_ch1_gain_fine,
   input wire logic [7:0] o_ch2_clamp_level,
   input wire logic [5:0] o_ch2_gain_coarse,
   input wire logic [4:0] o_ch2_gain_fine
);
   // ****************************************
   // Reset values and bus timing
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_reset_level: assert property ($rose(i_rst_n) |->
      o_ch1_clamp_level == 8'h80 && o_ch2_clamp_level == 8'h80)
      else $error("level not mid-range after reset");
   a_reset_coarse: assert property ($rose(i_rst_n) |->
      o_ch1_gain_coarse == 6'h20 && o_ch2_gain_coarse == 6'h20)
      else $error("coarse gain wrong after reset");
   a_reset_fine: assert property ($rose(i_rst_n) |->
      o_ch1_gain_fine == 5'h10 && o_ch2_gain_fine == 5'h10)
      else $error("fine gain wrong after reset");
   a_reset_span: assert property ($rose(i_rst_n) |->
      o_clamp_span == 3'h0)
      else $error("span not bottom after reset");
   a_reset_clamp: assert property ($rose(i_rst_n) |->
      o_ch_clamp == 3'h0)
      else $error("clamp pulse active after reset");
   // Data must not move while the host samples it
   a_sda_steady: assert property (i_scl && $past(i_scl)
      && $past(i_rst_n) |-> $stable(o_sda_oe_n))
      else $error("device data moved with clock high");
   // Settings change only on a byte end, with the bus clock low
   a_level_on_low: assert property ($past(i_rst_n) &&
      !$stable({o_ch1_clamp_level, o_ch2_clamp_level}) |-> !i_scl)
      else $error("level changed with clock high");
   a_gain_on_low: assert property ($past(i_rst_n) &&
      !$stable({o_clamp_span, o_ch1_gain_coarse, o_ch1_gain_fine,
      o_ch2_gain_coarse, o_ch2_gain_fine}) |-> !i_scl && !$past(i_scl))
      else $error("setting changed with clock high");
endmodule

// [dv/tb_dcg_regs.sv]
/* Bench of the clamp and gain register bank: host model on the bus,
   random values from a fixed seed, corner cases by hand.
   Assumes the host model and the port checker are compiled with it. */
`timescale 1ns/1ns
module tb_dcg_regs;
   import dcg_pkg::*;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                pix_en = 1'b0;
   logic                lsync = 1'b0;
   logic                ext = 1'b0;
   logic [STEP_W-1:0]   step = '0;
   logic [STEP_W-1:0]   old;
   logic [31:0]         seed = 32'd55;
   logic [7:0]          q [16];
   logic [7:0]          v [11];
   logic [2:0]          clamp, span;
   logic [7:0]          lv1, lv2;
   logic [5:0]          co1, co2;
   logic [4:0]          fi1, fi2;
   logic                a_n;
   logic [11:0]         b, e;
   int                  pts [4];
   int                  fail_count = 0;
   int                  check_count = 0;
   wire                 scl, h_oe_n, d_sda, d_oe_n;
   // Open-drain data line with its pull-up
   wire                 sda = h_oe_n & (d_oe_n | d_sda);
   // Reset values and live bits of 0x20..0x2a
   localparam logic [7:0] RST [11] = '{8'h2a, 8'h02, 8'h00, 8'h40,
      8'h00, 8'h80, 8'h20, 8'h10, 8'h80, 8'h20, 8'h10};
   localparam logic [7:0] MSK [11] = '{8'h7f, 8'hff, 8'h0f, 8'hff,
      8'h0f, 8'hff, 8'h3f, 8'h1f, 8'hff, 8'h3f, 8'h1f};

   always #20 clk = ~clk;

   dcg_regs dcg_regs_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl),
      .i_sda(sda), .o_sda(d_sda), .o_sda_oe_n(d_oe_n),
      .i_phase_step_value(step), .i_pixel_en(pix_en),
      .i_line_sync_input(lsync), .i_ext_clamp(ext), .o_ch_clamp(clamp),
      .o_clamp_span(span), .o_ch1_clamp_level(lv1),
      .o_ch1_gain_coarse(co1), .o_ch1_gain_fine(fi1),
      .o_ch2_clamp_level(lv2), .o_ch2_gain_coarse(co2),
      .o_ch2_gain_fine(fi2));
   dcg_host dcg_host_i (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe_n(h_oe_n));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [2:0] win(input int n, input logic [2:0] en);
      return (n >= b && n <= e) ? en : 3'h0;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Sync edge, n pixel pulses, then time for the output to settle
   task automatic line(input int n);
      lsync <= 1'b1;
      @(posedge clk);
      lsync <= 1'b0;
      repeat (2) @(posedge clk);
      repeat (n) begin
         pix_en <= 1'b1;
         @(posedge clk);
         pix_en <= 1'b0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask

   // Hang guard
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      dcg_host_i.rd(8'h20, 11, q, a_n);
      foreach (RST[i])
         chk(q[i], RST[i]);
      $display("test reset values done");
      foreach (v[i]) begin
         v[i] = 8'(rnd());
         dcg_host_i.wr(8'h20 + 8'(i), v[i], a_n);
      end
      dcg_host_i.rd(8'h20, 11, q, a_n);
      foreach (v[i])
         chk(q[i], v[i] & MSK[i]);
      chk({lv1, co1, fi1, lv2, co2, fi2},
         {v[5], v[6][5:0], v[7][4:0], v[8], v[9][5:0], v[10][4:0]});
      chk(span, {v[0][0], v[0][2], v[0][4]});
      $display("test random settings done");
      // Read-only and unmapped places are acked but keep nothing
      step <= {1'b1, rnd()};
      dcg_host_i.wr(8'h14, 8'h5a, a_n);
      chk(a_n, 1'b0);
      dcg_host_i.wr(8'h40, 8'h5a, a_n);
      dcg_host_i.rd(8'h40, 1, q, a_n);
      chk(q[0], 8'h00);
      // Increment moves in mid-read; the burst keeps the old value
      old = step;
      fork
         dcg_host_i.rd(8'h14, 5, q, a_n);
         begin
            repeat (450) @(posedge clk);
            step <= ~step;
         end
      join
      chk({q[4], q[3], q[2], q[1], q[0]}, {7'h0, old});
      dcg_host_i.rd(8'h14, 5, q, a_n);
      chk({q[4], q[3], q[2], q[1], q[0]}, {7'h0, step});
      $display("test increment done");
      dcg_host_i.rd(8'h19, 1, q, a_n);
      chk(q[0], 8'h01);
      line(0);
      dcg_host_i.rd(8'h19, 1, q, a_n);
      chk(q[0], 8'h00);
      $display("test sync status done");
      // Window of 62 pixels with channel 1 off, probed at both edges
      b = {4'h1, 8'(rnd())};
      e = b + 12'd61;
      dcg_host_i.wr(8'h21, b[7:0], a_n);
      dcg_host_i.wr(8'h22, {4'h0, b[11:8]}, a_n);
      dcg_host_i.wr(8'h23, e[7:0], a_n);
      dcg_host_i.wr(8'h24, {4'h0, e[11:8]}, a_n);
      dcg_host_i.wr(8'h20, 8'h22, a_n);
      pts = '{b - 1, b, e, e + 1};
      foreach (pts[i]) begin
         line(pts[i]);
         chk(clamp, win(pts[i], 3'b101));
      end
      // External source: the counter sits inside the window
      dcg_host_i.wr(8'h20, 8'h62, a_n);
      line(b);
      chk(clamp, 3'h0);
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      chk(clamp, 3'b101);
      ext <= 1'b0;
      $display("test clamp pulse done");
      complete_run();
   end
endmodule

bind dcg_regs dcg_regs_sva dcg_regs_sva_i (.i_clk_sys, .i_rst_n, .i_scl,
   .o_sda_oe_n, .o_ch_clamp, .o_clamp_span, .o_ch1_clamp_level,
   .o_ch1_gain_coarse, .o_ch1_gain_fine, .o_ch2_clamp_level,
   .o_ch2_gain_coarse, .o_ch2_gain_fine);
